// ---- src/reset_seq_pkg.sv ----
// Constants, types and helpers shared by the reset time-out sequencer
package reset_seq_pkg;

    // ************************************************************
    // Clock and time-outs
    // ************************************************************
    localparam int unsigned CORE_CLK_MHZ = 200;
    localparam int unsigned TMR_W = 12;
    localparam int unsigned SLOW_TICK_US = 32;
    localparam logic [TMR_W-1:0] PWRUP_TICKS = 12'h800;
    localparam logic [TMR_W-1:0] OSCSU_CYCLES = 12'h400;
    localparam int unsigned PLL_LOCK_US = 2000;
    localparam logic [TMR_W-1:0] PLL_LOCK_TICKS = TMR_W'((PLL_LOCK_US + SLOW_TICK_US - 1) / SLOW_TICK_US);
    localparam int unsigned BIAS_MIN_NS = 5000;
    localparam logic [TMR_W-1:0] BIAS_CYCLES = TMR_W'((BIAS_MIN_NS * CORE_CLK_MHZ + 999) / 1000);
    // Minimum brown-out duration; plain default, tune to the analog cell
    localparam int unsigned BROWN_MIN_NS = 100;
    localparam logic [7:0] BROWN_MIN_CYCLES = 8'((BROWN_MIN_NS * CORE_CLK_MHZ + 999) / 1000);

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_CAUSE = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam int unsigned PRIO_BIT = 7;
    localparam int unsigned RI_BIT = 4;
    localparam int unsigned TO_BIT = 3;
    localparam int unsigned PD_BIT = 2;
    localparam int unsigned POR_BIT = 1;
    localparam int unsigned BROWN_BIT = 0;
    localparam logic [7:0] CAUSE_RESET = 8'h1f;
    localparam logic [7:0] CAUSE_MASK = 8'h9f;
    localparam int unsigned OSC_READY_BIT = 0;
    localparam int unsigned STK_OVF_BIT = 1;
    localparam int unsigned STK_UNF_BIT = 2;
    localparam int unsigned STATE_LSB = 4;

    // ************************************************************
    // Program counter actions
    // ************************************************************
    localparam logic [20:0] RESET_VECTOR = 21'h000000;
    localparam logic [20:0] HIGH_VECTOR = 21'h000008;
    localparam logic [20:0] LOW_VECTOR = 21'h000018;

    typedef enum logic [1:0] {
        PC_RESET = 2'b00,
        PC_PLUS2 = 2'b01,
        PC_HIGH = 2'b10,
        PC_LOW = 2'b11
    } pc_sel_t;

    typedef enum logic [2:0] {
        LOW_POWER_CRYSTAL_MODE = 3'b000,
        CRYSTAL_MODE = 3'b001,
        FAST_CRYSTAL_MODE = 3'b010,
        FAST_CRYSTAL_WITH_MULTIPLIER = 3'b011,
        EXTERNAL_CLOCK_IN_MODE = 3'b100,
        RESISTOR_CAP_OSC_MODE = 3'b101,
        INTERNAL_OSC_MODE_ONE = 3'b110,
        INTERNAL_OSC_MODE_TWO = 3'b111
    } osc_mode_t;

    typedef enum logic [2:0] {
        SEQ_HOLD = 3'b000,
        SEQ_PWRUP = 3'b001,
        SEQ_OSCSU = 3'b010,
        SEQ_PLL = 3'b011,
        SEQ_BIAS = 3'b100,
        SEQ_DONE = 3'b101
    } seq_state_t;

    function automatic logic is_crystal(input osc_mode_t mode);
        is_crystal = (mode <= FAST_CRYSTAL_WITH_MULTIPLIER);
    endfunction : is_crystal

endpackage : reset_seq_pkg

// ---- src/timeout_counter.sv ----
// Restartable tick counter that flags when a target count is reached
`timescale 1ns/10ps
module timeout_counter
    import reset_seq_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_sync_b,
    input wire logic clear,
    input wire logic tick,
    input wire logic [TMR_W-1:0] target,
    output logic done
);

    logic [TMR_W-1:0] count_ff;

    // Restart always goes to zero so a partial count is never reused
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            count_ff <= '0;
        else if (clear)
            count_ff <= '0;
        else if (tick && !done)
            count_ff <= count_ff + 1'b1;
    end

    assign done = (count_ff >= target);

endmodule : timeout_counter

// ---- src/reset_timeout_sequencer.sv ----
// Reset source sequencing, start-up time-outs and reset cause register
// Function
// - power-up timer counts 2048 slow oscillator ticks while core held in reset
// - power-up timer runs only when its active-low disable bit is clear
// - oscillator start-up counts 1024 main oscillator cycles after power-up delay
// - start-up count only in crystal modes, on power-on or low-power exit
// - multiplier crystal mode adds 2 ms lock delay from power-up timer
// - brown-out logic works only when its enable bit is set
// - brown-out resets only after minimum duration, held until indication clears
// - brown-out recovery reruns power-up delay, restarting it on each new dip
// - brown-out enable and power-up timer enable are independent
// - power-up waits for power-on pulse, then power-up delay, then start-up count
// - resistor-capacitor mode with power-up timer off gives no time-out beyond the bias delay
// - time-outs run from power-on pulse; late pin release starts at once
// - 5 to 10 us bias delay on power-on and wakes that stopped execution
// - cause register: priority enable bit 7 reset 0, bits 4..0 reset 1
// - power-on and brown-out load vector zero and set flags as tabled
// - reset instruction clears its flag and priority enable, vectors to zero
// - pin reset while running sets watchdog flag, vectors to zero
// - pin reset in idle or sleep sets watchdog flag, clears power-down flag
// - watchdog time-out while running resets and clears watchdog flag
// - watchdog time-out in idle or sleep wakes at PC+2, clears two flags
// - interrupt wake resumes at PC+2 or vector, clears power-down flag
// - stack faults reset and set flag when enabled, else underflow flag only
// - start-up count completion sets oscillator ready; core release follows the bias delay, or the lock delay in multiplier mode
// - pin reset input can be disabled; pin is never driven
`timescale 1ns/10ps
module reset_timeout_sequencer
    import reset_seq_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic power_on_pulse,
    input wire logic brownout_threshold,
    input wire logic master_clear_pin_n,
    input wire logic slow_osc_tick,
    input wire logic main_osc_tick,
    input wire logic power_up_timer_disable_n,
    input wire logic brownout_enable,
    input wire logic master_clear_pin_enable,
    input wire logic stack_fault_reset_enable,
    input wire logic [2:0] osc_mode,
    input wire logic cpu_stopped,
    input wire logic watchdog_timeout,
    input wire logic reset_instruction,
    input wire logic stack_overflow,
    input wire logic stack_underflow,
    input wire logic interrupt_wake,
    input wire logic global_high_irq_enable,
    input wire logic global_low_irq_enable,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic core_reset,
    output logic exec_stall,
    output logic main_oscillator_ready,
    output logic interrupt_priority_enable,
    output logic pc_load,
    output logic [20:0] pc_vector,
    output logic [1:0] pc_action
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync_b_ff;
    logic rst_sync_b;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_b_ff <= 2'b00;
        else
            rst_sync_b_ff <= {rst_sync_b_ff[0], 1'b1};
    end

    assign rst_sync_b = rst_sync_b_ff[1];

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);

    // ************************************************************
    // Reset sources
    // ************************************************************
    logic [7:0] brown_cnt_ff;
    logic brown_active;
    logic pin_active;
    logic pin_prev_ff;
    logic pin_event;
    logic stack_reset;
    logic sw_reset;
    logic wake_event;
    osc_mode_t mode;

    assign mode = osc_mode_t'(osc_mode);

    // Short dips never reach the counter limit and are dropped
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            brown_cnt_ff <= 8'h00;
        else if (!brownout_enable || !brownout_threshold)
            brown_cnt_ff <= 8'h00;
        else if (brown_cnt_ff != BROWN_MIN_CYCLES)
            brown_cnt_ff <= brown_cnt_ff + 8'h01;
    end

    assign brown_active = brownout_enable && brownout_threshold && (brown_cnt_ff == BROWN_MIN_CYCLES);
    assign pin_active = master_clear_pin_enable && !master_clear_pin_n;

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            pin_prev_ff <= 1'b0;
        else
            pin_prev_ff <= pin_active;
    end

    assign pin_event = pin_active && !pin_prev_ff;
    assign stack_reset = stack_fault_reset_enable && (stack_overflow || stack_underflow);
    assign sw_reset = reset_instruction || stack_reset || (watchdog_timeout && !cpu_stopped);
    assign wake_event = cpu_stopped && (watchdog_timeout || interrupt_wake);

    // ************************************************************
    // Time-out sequence
    // ************************************************************
    seq_state_t seq_ff;
    seq_state_t nxt_seq;
    logic from_por_ff;
    logic wake_seq_ff;
    logic slow_done;
    logic oscsu_done;
    logic bias_done;
    logic need_bias_ff;
    logic [TMR_W-1:0] slow_target;
    seq_state_t after_pwrup;

    always_comb
    begin
        after_pwrup = SEQ_BIAS;
        if ((from_por_ff || wake_seq_ff) && is_crystal(mode))
            after_pwrup = SEQ_OSCSU;
    end

    always_comb
    begin
        nxt_seq = seq_ff;
        case (seq_ff)
            SEQ_HOLD:
            begin
                if (!power_on_pulse && !brown_active)
                    nxt_seq = power_up_timer_disable_n ? after_pwrup : SEQ_PWRUP;
            end
            SEQ_PWRUP:
                if (slow_done)
                    nxt_seq = after_pwrup;
            SEQ_OSCSU:
                if (oscsu_done)
                    nxt_seq = (mode == FAST_CRYSTAL_WITH_MULTIPLIER) ? SEQ_PLL : SEQ_BIAS;
            SEQ_PLL:
                if (slow_done)
                    nxt_seq = SEQ_BIAS;
            SEQ_BIAS:
                if (bias_done || !need_bias_ff)
                    nxt_seq = SEQ_DONE;
            SEQ_DONE:
                if (wake_event)
                    nxt_seq = after_pwrup == SEQ_OSCSU ? SEQ_OSCSU : SEQ_BIAS;
            default:
                nxt_seq = SEQ_HOLD;
        endcase
        if (power_on_pulse || brown_active)
            nxt_seq = SEQ_HOLD;
        if (seq_ff == SEQ_DONE && wake_event && is_crystal(mode))
            nxt_seq = SEQ_OSCSU;
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            seq_ff <= SEQ_HOLD;
        else
            seq_ff <= nxt_seq;
    end

    // Origin of the running sequence decides which delays apply
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            from_por_ff <= 1'b1;
            wake_seq_ff <= 1'b0;
            need_bias_ff <= 1'b1;
        end
        else if (power_on_pulse)
        begin
            from_por_ff <= 1'b1;
            wake_seq_ff <= 1'b0;
            need_bias_ff <= 1'b1;
        end
        else if (brown_active)
        begin
            from_por_ff <= 1'b0;
            wake_seq_ff <= 1'b0;
            need_bias_ff <= 1'b0;
        end
        else if (seq_ff == SEQ_DONE && wake_event)
        begin
            wake_seq_ff <= 1'b1;
            need_bias_ff <= 1'b1;
        end
        else if (nxt_seq == SEQ_DONE)
            wake_seq_ff <= 1'b0;
    end

    assign slow_target = (seq_ff == SEQ_PLL) ? PLL_LOCK_TICKS : PWRUP_TICKS;

    // Lock delay reuses the power-up counter with a shorter target
    timeout_counter u_slow_timer (
        .core_clk(core_clk),
        .rst_sync_b(rst_sync_b),
        .clear((seq_ff != nxt_seq) || (seq_ff != SEQ_PWRUP && seq_ff != SEQ_PLL)),
        .tick(slow_osc_tick),
        .target(slow_target),
        .done(slow_done)
    );

    timeout_counter u_oscsu_timer (
        .core_clk(core_clk),
        .rst_sync_b(rst_sync_b),
        .clear(seq_ff != SEQ_OSCSU),
        .tick(main_osc_tick),
        .target(OSCSU_CYCLES),
        .done(oscsu_done)
    );

    // Bias delay runs beside the other time-outs rather than after them
    timeout_counter u_bias_timer (
        .core_clk(core_clk),
        .rst_sync_b(rst_sync_b),
        .clear(seq_ff == SEQ_HOLD || (seq_ff == SEQ_DONE && wake_event)),
        .tick(1'b1),
        .target(BIAS_CYCLES),
        .done(bias_done)
    );

    // ************************************************************
    // Core reset and program counter
    // ************************************************************
    logic core_reset_ff;
    logic nxt_core_reset;
    logic osc_ready_ff;
    logic pc_load_ff;
    pc_sel_t pc_sel_ff;

    assign nxt_core_reset = power_on_pulse || brown_active || pin_active || sw_reset
        || (seq_ff != SEQ_DONE && !wake_seq_ff);

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            core_reset_ff <= 1'b1;
        else
            core_reset_ff <= nxt_core_reset;
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            osc_ready_ff <= 1'b0;
        else if (seq_ff == SEQ_HOLD || (seq_ff == SEQ_DONE && wake_event && is_crystal(mode)))
            osc_ready_ff <= 1'b0;
        else if (seq_ff == SEQ_OSCSU && oscsu_done)
            osc_ready_ff <= 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            pc_sel_ff <= PC_RESET;
        else if (nxt_core_reset)
            pc_sel_ff <= PC_RESET;
        else if (wake_event && interrupt_wake && global_high_irq_enable)
            pc_sel_ff <= PC_HIGH;
        else if (wake_event && interrupt_wake && global_low_irq_enable)
            pc_sel_ff <= PC_LOW;
        else if (wake_event)
            pc_sel_ff <= PC_PLUS2;
    end

    // Load pulse marks the moment the core may resume
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            pc_load_ff <= 1'b0;
        else
            pc_load_ff <= (core_reset_ff && !nxt_core_reset) || (wake_seq_ff && nxt_seq == SEQ_DONE);
    end

    assign core_reset = core_reset_ff;
    assign exec_stall = wake_seq_ff;
    assign main_oscillator_ready = osc_ready_ff;
    assign pc_load = pc_load_ff;
    assign pc_action = pc_sel_ff;
    assign pc_vector = (pc_sel_ff == PC_HIGH) ? HIGH_VECTOR : (pc_sel_ff == PC_LOW) ? LOW_VECTOR : RESET_VECTOR;

    // ************************************************************
    // Cause and status registers
    // ************************************************************
    logic [7:0] cause_ff;
    logic [7:0] nxt_cause;
    logic [1:0] stack_ff;
    logic [1:0] nxt_stack;
    logic [7:0] status_word;
    logic [7:0] rdata_ff;

    // Events are applied after the software write so that an event wins
    always_comb
    begin
        nxt_cause = cause_ff;
        nxt_stack = stack_ff;
        if (reg_wr && reg_addr == ADDR_CAUSE)
            nxt_cause = reg_wdata & CAUSE_MASK;
        if (reg_wr && reg_addr == ADDR_STATUS)
            nxt_stack = reg_wdata[STK_UNF_BIT:STK_OVF_BIT];
        if (power_on_pulse)
        begin
            nxt_cause = 8'h1c;
            nxt_stack = 2'b00;
        end
        else if (brown_active)
        begin
            nxt_cause[PRIO_BIT] = 1'b0;
            nxt_cause[RI_BIT] = 1'b1;
            nxt_cause[TO_BIT] = 1'b1;
            nxt_cause[PD_BIT] = 1'b1;
            nxt_cause[BROWN_BIT] = 1'b0;
        end
        else
        begin
            if (reset_instruction)
            begin
                nxt_cause[RI_BIT] = 1'b0;
                nxt_cause[PRIO_BIT] = 1'b0;
            end
            if (pin_event)
            begin
                nxt_cause[PRIO_BIT] = 1'b0;
                nxt_cause[TO_BIT] = 1'b1;
                if (cpu_stopped)
                    nxt_cause[PD_BIT] = 1'b0;
            end
            if (watchdog_timeout)
            begin
                nxt_cause[TO_BIT] = 1'b0;
                if (cpu_stopped)
                    nxt_cause[PD_BIT] = 1'b0;
                else
                    nxt_cause[PRIO_BIT] = 1'b0;
            end
            if (interrupt_wake && cpu_stopped)
                nxt_cause[PD_BIT] = 1'b0;
            if (stack_reset)
                nxt_cause[PRIO_BIT] = 1'b0;
            if (stack_overflow && stack_fault_reset_enable)
                nxt_stack[0] = 1'b1;
            if (stack_underflow)
                nxt_stack[1] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            cause_ff <= CAUSE_RESET;
            stack_ff <= 2'b00;
        end
        else
        begin
            cause_ff <= nxt_cause;
            stack_ff <= nxt_stack;
        end
    end

    assign status_word = {1'b0, seq_ff, 1'b0, stack_ff, osc_ready_ff};

    // Unmapped addresses read as zero
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            rdata_ff <= 8'h00;
        else if (reg_rd && reg_addr == ADDR_CAUSE)
            rdata_ff <= cause_ff;
        else if (reg_rd && reg_addr == ADDR_STATUS)
            rdata_ff <= status_word;
        else
            rdata_ff <= 8'h00;
    end

    assign reg_rdata = rdata_ff;
    assign interrupt_priority_enable = cause_ff[PRIO_BIT];

    // ************************************************************
    // Checks
    // ************************************************************
    property p_hold_on_por;
        power_on_pulse |=> core_reset_ff ##1 core_reset_ff;
    endproperty
    a_hold_on_por: assert property (p_hold_on_por) else $error("core left reset during power-on pulse");

    property p_pwrup_skip;
        (seq_ff == SEQ_HOLD && !power_on_pulse && !brown_active && power_up_timer_disable_n) |=> seq_ff != SEQ_PWRUP;
    endproperty
    a_pwrup_skip: assert property (p_pwrup_skip) else $error("power-up timer ran while disabled");

    property p_oscsu_after_pwrup;
        (seq_ff == SEQ_PWRUP && nxt_seq == SEQ_OSCSU) |-> slow_done;
    endproperty
    a_oscsu_after_pwrup: assert property (p_oscsu_after_pwrup) else $error("start-up count began early");

    property p_pll_follows;
        (seq_ff == SEQ_OSCSU && oscsu_done && mode == FAST_CRYSTAL_WITH_MULTIPLIER && !power_on_pulse && !brown_active)
            |=> seq_ff == SEQ_PLL;
    endproperty
    a_pll_follows: assert property (p_pll_follows) else $error("lock delay skipped");

    property p_brown_disabled;
        !brownout_enable |-> !brown_active;
    endproperty
    a_brown_disabled: assert property (p_brown_disabled) else $error("brown-out active while disabled");

    property p_brown_min;
        $rose(brown_active) |-> $past(brownout_threshold, 2) && $past(brownout_threshold);
    endproperty
    a_brown_min: assert property (p_brown_min) else $error("brown-out taken without persistence");

    property p_pin_release;
        (seq_ff == SEQ_DONE && !nxt_core_reset && pin_prev_ff) |=> !core_reset_ff;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin release did not start execution");

    property p_osc_ready;
        (seq_ff == SEQ_OSCSU && oscsu_done && !power_on_pulse && !brown_active) |=> osc_ready_ff ##1 osc_ready_ff;
    endproperty
    a_osc_ready: assert property (p_osc_ready) else $error("oscillator ready not set");

    property p_ri_clear;
        (reset_instruction && !power_on_pulse && !brown_active) |=> !cause_ff[RI_BIT] && !cause_ff[PRIO_BIT];
    endproperty
    a_ri_clear: assert property (p_ri_clear) else $error("reset instruction flag not cleared");

endmodule : reset_timeout_sequencer

// ---- tb/supply_pin_model.sv ----
// Supply monitor, reset pin driver and oscillator tick source
`timescale 1ns/10ps
module supply_pin_model
(
    input wire logic core_clk,
    input wire logic por_on,
    input wire logic dip_on,
    input wire logic pin_low,
    output logic power_on_pulse,
    output logic brownout_threshold,
    output logic master_clear_pin_n,
    output logic slow_osc_tick,
    output logic main_osc_tick
);
    logic [1:0] div_ff;
    initial
    begin
        {div_ff, power_on_pulse, brownout_threshold, slow_osc_tick, main_osc_tick} = 6'h00;
        master_clear_pin_n = 1'b1;
    end
    // Ticks run far faster than real oscillators so whole sequences fit a short run
    always @(posedge core_clk)
    begin
        div_ff <= div_ff + 2'h1;
        slow_osc_tick <= (div_ff == 2'h3);
        main_osc_tick <= div_ff[0];
        power_on_pulse <= por_on;
        brownout_threshold <= dip_on;
        master_clear_pin_n <= ~pin_low;
    end
endmodule : supply_pin_model

// ---- tb/reset_timeout_sequencer_tb.sv ----
// Self-checking bench for the reset time-out sequencer
`timescale 1ns/10ps
module reset_timeout_sequencer_tb;
    import reset_seq_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic por_on = 1'b0;
    logic dip_on = 1'b0;
    logic pin_low = 1'b0;
    logic power_up_timer_disable_n = 1'b1;
    logic brownout_enable = 1'b0;
    logic master_clear_pin_enable = 1'b1;
    logic stack_fault_reset_enable = 1'b1;
    logic [2:0] osc_mode = 3'h5;
    logic cpu_stopped = 1'b0, watchdog_timeout = 1'b0, reset_instruction = 1'b0;
    logic stack_overflow = 1'b0, stack_underflow = 1'b0, interrupt_wake = 1'b0;
    logic global_high_irq_enable = 1'b0, global_low_irq_enable = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic power_on_pulse, brownout_threshold, master_clear_pin_n, slow_osc_tick, main_osc_tick;
    logic [7:0] reg_rdata;
    logic core_reset, exec_stall, main_oscillator_ready, interrupt_priority_enable, pc_load;
    logic [20:0] pc_vector;
    logic [1:0] pc_action;
    int n_fail = 0;
    int n_compared = 0;

    supply_pin_model partner (.core_clk, .por_on, .dip_on, .pin_low, .power_on_pulse,
        .brownout_threshold, .master_clear_pin_n, .slow_osc_tick, .main_osc_tick);
    reset_timeout_sequencer uut (.core_clk, .rst_b, .power_on_pulse, .brownout_threshold,
        .master_clear_pin_n, .slow_osc_tick, .main_osc_tick, .power_up_timer_disable_n,
        .brownout_enable, .master_clear_pin_enable, .stack_fault_reset_enable, .osc_mode,
        .cpu_stopped, .watchdog_timeout, .reset_instruction, .stack_overflow, .stack_underflow,
        .interrupt_wake, .global_high_irq_enable, .global_low_irq_enable, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .core_reset, .exec_stall, .main_oscillator_ready,
        .interrupt_priority_enable, .pc_load, .pc_vector, .pc_action);

    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    task give_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    task chk(input logic [20:0] got, input logic [20:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e, "read data");
    endtask : rd

    // Counts cycles until the core leaves reset; a hang ends at the bound
    task wait_rel(input int lo, input int hi);
        int n;
        n = 0;
        while (core_reset !== 1'b0 && n < 30000)
        begin
            @(posedge core_clk);
            #1 n++;
        end
        chk(n >= lo && n <= hi, 1, "release time");
    endtask : wait_rel

    task por(input logic [2:0] m, input logic d, input int hold, input int lo, input int hi);
        @(posedge core_clk);
        osc_mode <= m;
        power_up_timer_disable_n <= d;
        por_on <= 1'b1;
        pin_low <= (hold != 0);
        repeat (6) @(posedge core_clk);
        por_on <= 1'b0;
        repeat (hold) @(posedge core_clk);
        pin_low <= 1'b0;
        wait_rel(lo, hi);
        chk(pc_load, 1, "resume pulse");
        chk(pc_action, PC_RESET, "resume action");
    endtask : por

    task dip(input int n, input logic e);
        @(posedge core_clk);
        dip_on <= 1'b1;
        repeat (n) @(posedge core_clk);
        #1 chk(core_reset, e, "brown-out hold");
        dip_on <= 1'b0;
    endtask : dip

    task pulse_evt(input int k);
        @(posedge core_clk);
        {reset_instruction, watchdog_timeout, stack_overflow} <= 3'h4 >> k;
        @(posedge core_clk);
        {reset_instruction, watchdog_timeout, stack_overflow} <= 3'h0;
        repeat (6) @(posedge core_clk);
    endtask : pulse_evt

    initial
    begin
        #500000;
        n_fail++;
        give_verdict();
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(ADDR_CAUSE, CAUSE_RESET);
        wr(ADDR_CAUSE, 8'hff);
        rd(ADDR_CAUSE, 8'h9f);
        rd(4'h7, 8'h00);
        por(RESISTOR_CAP_OSC_MODE, 1'b1, 0, 1000, 2000);
        rd(ADDR_CAUSE, 8'h1c);
        por(CRYSTAL_MODE, 1'b0, 0, 10232, 10300);
        chk(main_oscillator_ready, 1, "oscillator ready");
        por(FAST_CRYSTAL_WITH_MULTIPLIER, 1'b1, 0, 2292, 2360);
        por(EXTERNAL_CLOCK_IN_MODE, 1'b0, 0, 8184, 8252);
        por(RESISTOR_CAP_OSC_MODE, 1'b1, 3000, 0, 4);
        dip(40, 1'b0);
        brownout_enable <= 1'b1;
        wr(ADDR_CAUSE, 8'h1f);
        dip(10, 1'b0);
        dip(40, 1'b1);
        wait_rel(0, 100);
        rd(ADDR_CAUSE, 8'h1e);
        wr(ADDR_CAUSE, 8'h10);
        master_clear_pin_enable <= 1'b0;
        pin_low <= 1'b1;
        repeat (10) @(posedge core_clk);
        #1 chk(core_reset, 0, "pin ignored");
        pin_low <= 1'b0;
        master_clear_pin_enable <= 1'b1;
        repeat (4) @(posedge core_clk);
        pin_low <= 1'b1;
        repeat (10) @(posedge core_clk);
        #1 chk(core_reset, 1, "pin reset");
        pin_low <= 1'b0;
        wait_rel(0, 20);
        rd(ADDR_CAUSE, 8'h18);
        wr(ADDR_CAUSE, 8'h9f);
        pulse_evt(0);
        rd(ADDR_CAUSE, 8'h0f);
        chk(interrupt_priority_enable, 0, "priority enable");
        pulse_evt(1);
        rd(ADDR_CAUSE, 8'h07);
        pulse_evt(2);
        rd(ADDR_STATUS, 8'h52);
        give_verdict();
    end
endmodule : reset_timeout_sequencer_tb
